// [sbsc_top.sv]
// Cycle control of a pipelined synchronous burst SRAM with its array.
// Assumes one bus master on clk; output enable and sleep are levels.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_map.svh"

module sbsc_top (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       reset,
   // Address and data
   input  wire logic [`SBSC_ADDR_W-1:0]    addr,
   input  wire logic [`SBSC_DATA_W-1:0]    data_in,
   output logic      [`SBSC_DATA_W-1:0]    data_out,
   output logic                            data_oe,
   // Chip selects
   input  wire logic                       primary_select_n,
   input  wire logic                       depth_select_hi,
   input  wire logic                       depth_select_lo_n,
   // Burst control
   input  wire logic                       processor_addr_strobe_n,
   input  wire logic                       controller_addr_strobe_n,
   input  wire logic                       burst_advance_n,
   input  wire logic                       burst_mode_interleaved,
   // Write control
   input  wire logic                       global_write_n,
   input  wire logic                       byte_write_enable_n,
   input  wire logic [`SBSC_LANES-1:0]     byte_lane_select_n,
   // Output enable and sleep
   input  wire logic                       output_enable_n,
   input  wire logic                       sleep_request,
   // Status
   output logic                            sleep_state,
   output logic                            burst_active
);
   import sbsc_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   sbsc_ctl_if ctl ();

   sbsc_op_type                          op;           // Cycle kind this edge
   logic                                 chip_sel;     // All selects active
   logic                                 proc_start;   // Processor strobe honoured
   logic                                 block;        // Sleep ignores inputs
   logic                                 write_req;    // Write inputs ask a write
   logic                                 cycle_write;  // This edge writes
   logic                                 cycle_read;   // This edge reads
   logic [`SBSC_LANES-1:0]               write_lanes;  // Lanes to store
   logic [`SBSC_ADDR_W-1:0]              acc_addr;     // Address used this edge
   logic [`SBSC_ADDR_W-1:`SBSC_CNT_W]    upper_q;      // Fixed burst upper bits
   logic [`SBSC_ADDR_W-1:0]              rd_addr_q;    // Registered read address
   logic                                 rd_valid_q;   // Read registered
   logic                                 out_read_q;   // Output register holds read
   logic                                 write_q;      // Last edge was a write
   logic [`SBSC_DATA_W-1:0]              mem [0:(2**`SBSC_ADDR_W)-1];  // Array

   // Lanes that the write inputs select; empty means a read
   function automatic logic [`SBSC_LANES-1:0] lane_enables(
      input logic                   glob_n,
      input logic                   byte_n,
      input logic [`SBSC_LANES-1:0] sel_n);
      if (!glob_n) begin
         lane_enables = '1;
      end else if (!byte_n) begin
         lane_enables = ~sel_n;
      end else begin
         lane_enables = '0;
      end
   endfunction

   // ----------------------------------------
   // Submodules
   // ----------------------------------------
   sbsc_burst_counter u_counter (
      .clk   (clk),
      .reset (reset),
      .ctl   (ctl)
   );

   sbsc_sleep_ctrl u_sleep (
      .clk   (clk),
      .reset (reset),
      .ctl   (ctl)
   );

   // ----------------------------------------
   // Input decode
   // ----------------------------------------
   // Processor strobe counts only with the primary select low
   assign chip_sel    = !primary_select_n && depth_select_hi && !depth_select_lo_n;
   assign proc_start  = !processor_addr_strobe_n && !primary_select_n;
   // Request level or a sleep still in progress freezes all decode
   assign block       = sleep_request || ctl.asleep;
   assign write_lanes = lane_enables(global_write_n, byte_write_enable_n,
                                     byte_lane_select_n);
   assign write_req   = |write_lanes;

   // Cycle kind, strobe starts take priority over burst steps
   always_comb begin
      op = SBSC_OP_IDLE;
      if (block) begin
         op = SBSC_OP_IDLE;
      end else if (proc_start && chip_sel) begin
         op = SBSC_OP_BEGIN;
      end else if (!controller_addr_strobe_n && chip_sel) begin
         op = SBSC_OP_BEGIN;
      end else if ((primary_select_n && !controller_addr_strobe_n) ||
                   (!primary_select_n && !(depth_select_hi && !depth_select_lo_n) &&
                    (!processor_addr_strobe_n || !controller_addr_strobe_n))) begin
         op = SBSC_OP_DESELECT;
      end else if (burst_active) begin
         // Both strobes idle here, or the processor strobe ignored
         op = burst_advance_n ? SBSC_OP_SUSPEND : SBSC_OP_CONTINUE;
      end
   end

   // Read or write: a processor start never writes
   always_comb begin
      cycle_write = 1'b0;
      cycle_read  = 1'b0;
      case (op)
         SBSC_OP_BEGIN: begin
            cycle_write = !proc_start && write_req;
            cycle_read  = proc_start || !write_req;
         end
         SBSC_OP_CONTINUE,
         SBSC_OP_SUSPEND: begin
            cycle_write = write_req;
            cycle_read  = !write_req;
         end
         default: begin
            cycle_write = 1'b0;
            cycle_read  = 1'b0;
         end
      endcase
   end

   // Address used by the array this edge
   always_comb begin
      case (op)
         SBSC_OP_CONTINUE: acc_addr = {upper_q, ctl.next_low};
         SBSC_OP_SUSPEND:  acc_addr = {upper_q, ctl.low};
         default:          acc_addr = addr;
      endcase
   end

   // ----------------------------------------
   // Burst counter control
   // ----------------------------------------
   // Mode is a static strap; it is passed through live
   assign ctl.interleaved = burst_mode_interleaved;
   assign ctl.load        = (op == SBSC_OP_BEGIN);
   assign ctl.start       = addr[`SBSC_CNT_W-1:0];
   assign ctl.advance     = (op == SBSC_OP_CONTINUE);
   assign ctl.sleep_req   = sleep_request;

   // ----------------------------------------
   // Burst state
   // ----------------------------------------
   // Deselect and sleep both end the burst; a pending one is lost
   always_ff @(posedge clk) begin
      if (reset) begin
         burst_active <= 1'b0;
      end else if (block) begin
         burst_active <= 1'b0;
      end else if (op == SBSC_OP_BEGIN) begin
         burst_active <= 1'b1;
      end else if (op == SBSC_OP_DESELECT) begin
         burst_active <= 1'b0;
      end
   end

   // Upper bits are captured only at a start and then held
   always_ff @(posedge clk) begin
      if (reset) begin
         upper_q <= '0;
      end else if (op == SBSC_OP_BEGIN) begin
         upper_q <= addr[`SBSC_ADDR_W-1:`SBSC_CNT_W];
      end
   end

   // ----------------------------------------
   // Array writes
   // ----------------------------------------
   // Self-timed write on the edge itself; no write can happen while
   // sleeping, which keeps the contents intact
   always_ff @(posedge clk) begin
      if (cycle_write) begin
         for (int l = 0; l < `SBSC_LANES; l++) begin
            if (write_lanes[l]) begin
               mem[acc_addr][l*`SBSC_LANE_W +: `SBSC_LANE_W] <=
                  data_in[l*`SBSC_LANE_W +: `SBSC_LANE_W];
            end
         end
      end
   end

   // ----------------------------------------
   // Read pipeline
   // ----------------------------------------
   // Address stage: the read is registered at the access edge
   always_ff @(posedge clk) begin
      if (reset) begin
         rd_addr_q  <= '0;
         rd_valid_q <= 1'b0;
         write_q    <= 1'b0;
      end else begin
         rd_addr_q  <= acc_addr;
         rd_valid_q <= cycle_read;
         write_q    <= cycle_write;
      end
   end

   // Output stage: data reaches the pins after the following edge;
   // a deselect therefore releases the bus one edge late
   always_ff @(posedge clk) begin
      if (reset) begin
         data_out   <= '0;
         out_read_q <= 1'b0;
      end else begin
         out_read_q <= rd_valid_q;
         if (rd_valid_q) begin
            data_out <= mem[rd_addr_q];
         end
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   // Output enable acts without the clock; writes and sleep override it
   assign data_oe = out_read_q && !write_q && !output_enable_n &&
                    !sleep_request && !ctl.asleep;

   assign sleep_state = ctl.asleep;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_sleep_tristate: assert property (@(posedge clk) disable iff (reset)
      sleep_request |-> !data_oe)
      else $error("data driven during sleep request");

   a_sleep_no_write: assert property (@(posedge clk) disable iff (reset)
      (ctl.asleep || sleep_request) |-> !cycle_write)
      else $error("array written while asleep");

   a_deselect_release: assert property (@(posedge clk) disable iff (reset)
      (op == SBSC_OP_DESELECT) |-> ##2 !data_oe)
      else $error("bus not released after deselect");

   a_proc_read_only: assert property (@(posedge clk) disable iff (reset)
      cycle_write |-> (!proc_start && (!controller_addr_strobe_n || burst_active)))
      else $error("write outside allowed cycle");

   a_read_latency: assert property (@(posedge clk) disable iff (reset)
      (cycle_read ##1 !cycle_write ##1 (!output_enable_n && !sleep_request && !ctl.asleep))
      |-> data_oe && data_out == mem[$past(acc_addr, 2)])
      else $error("read data not on bus after one edge");

   a_upper_fixed: assert property (@(posedge clk) disable iff (reset)
      (op != SBSC_OP_BEGIN) |=> $stable(upper_q))
      else $error("upper address changed in burst");

   a_write_mask: assert property (@(posedge clk) disable iff (reset)
      cycle_write |=> !data_oe)
      else $error("output enable not masked in write");

   a_suspend_addr: assert property (@(posedge clk) disable iff (reset)
      (op == SBSC_OP_SUSPEND) |-> (acc_addr[`SBSC_CNT_W-1:0] == ctl.low) ##1 (ctl.low == $past(ctl.low)))
      else $error("suspend did not reuse address");
endmodule

`default_nettype wire

// [sbsc_map.svh]
// Constants of the burst SRAM cycle controller: widths, reset values, timing.
// Assumes a 200 MHz core clock; included by every module file of the block.
`ifndef SBSC_MAP_SVH
`define SBSC_MAP_SVH

// ----------------------------------------
// Array shape
// ----------------------------------------
`define SBSC_ADDR_W 19
`define SBSC_DATA_W 36
`define SBSC_LANES 4
`define SBSC_LANE_W 9
`define SBSC_CNT_W 2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SBSC_CNT_RESET 2'h0
`define SBSC_SLEEP_CNT_RESET 3'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SBSC_CLK_PERIOD_PS 5000
`define SBSC_SLEEP_ENTRY_TIME_PS 10000
`define SBSC_SLEEP_RECOVERY_TIME_PS 10000
// Longest entry time rounds down, least recovery time rounds up
`define SBSC_SLEEP_ENTRY_CYCLES (`SBSC_SLEEP_ENTRY_TIME_PS / `SBSC_CLK_PERIOD_PS)
`define SBSC_SLEEP_EXIT_CYCLES \
   ((`SBSC_SLEEP_RECOVERY_TIME_PS + `SBSC_CLK_PERIOD_PS - 1) / `SBSC_CLK_PERIOD_PS)

`endif

// [sbsc_pkg.sv]
// Types of the burst SRAM cycle controller.
// Assumes sbsc_map.svh for all numeric constants.
`default_nettype none

package sbsc_pkg;

   // ----------------------------------------
   // Cycle kinds decoded at each clock rise
   // ----------------------------------------
   typedef enum logic [4:0] {
      SBSC_OP_IDLE     = 5'h01,
      SBSC_OP_DESELECT = 5'h02,
      SBSC_OP_BEGIN    = 5'h04,
      SBSC_OP_CONTINUE = 5'h08,
      SBSC_OP_SUSPEND  = 5'h10
   } sbsc_op_type;

   // ----------------------------------------
   // Sleep sequencer states
   // ----------------------------------------
   typedef enum logic [3:0] {
      SBSC_AWAKE    = 4'h1,
      SBSC_ENTERING = 4'h2,
      SBSC_ASLEEP   = 4'h4,
      SBSC_LEAVING  = 4'h8
   } sbsc_sleep_type;

endpackage

`default_nettype wire

// [sbsc_ctl_if.sv]
// Interface between the cycle core, the burst counter and the sleep sequencer.
// Assumes all three parties run on the same clock.
`timescale 1ns/1ps
`default_nettype none

interface sbsc_ctl_if;
   logic       load;         // Capture a new burst start
   logic       advance;      // Step to the next burst address
   logic       interleaved;  // Burst order select
   logic [1:0] start;        // Start value of low address bits
   logic [1:0] low;          // Current burst address bits
   logic [1:0] next_low;     // Address bits after one more step
   logic       sleep_req;    // Sleep request level
   logic       asleep;       // Sleeping or recovering

   modport counter (input load, advance, interleaved, start, output low, next_low);
   modport sleeper (input sleep_req, output asleep);
   modport core (output load, advance, interleaved, start, sleep_req,
                 input low, next_low, asleep);
endinterface

`default_nettype wire

// [sbsc_burst_counter.sv]
// Two-bit wraparound burst counter, linear or interleaved order.
// Assumes load and advance are never high together.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_map.svh"

module sbsc_burst_counter (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Control from the core
   sbsc_ctl_if.counter ctl
);
   import sbsc_pkg::*;

   logic [1:0] start_q;  // Start value held for the burst
   logic [1:0] count_q;  // Steps taken since the start

   // Address bits for a given step count in the chosen order
   function automatic logic [1:0] burst_bits(input logic il, input logic [1:0] s,
                                             input logic [1:0] c);
      burst_bits = il ? (s ^ c) : 2'(s + c);
   endfunction

   // ----------------------------------------
   // Counter state
   // ----------------------------------------
   // Load wins; otherwise step on each advance
   always_ff @(posedge clk) begin
      if (reset) begin
         start_q <= `SBSC_CNT_RESET;
         count_q <= `SBSC_CNT_RESET;
      end else if (ctl.load) begin
         start_q <= ctl.start;
         count_q <= `SBSC_CNT_RESET;
      end else if (ctl.advance) begin
         count_q <= 2'(count_q + 2'h1);
      end
   end

   assign ctl.low      = burst_bits(ctl.interleaved, start_q, count_q);
   assign ctl.next_low = burst_bits(ctl.interleaved, start_q, 2'(count_q + 2'h1));

   a_interleave_step: assert property (@(posedge clk) disable iff (reset)
      (ctl.interleaved && ctl.advance && !ctl.load && count_q == 2'h0)
      |=> (ctl.low == (start_q ^ 2'h1)))
      else $error("interleaved first step wrong");
   a_linear_wrap: assert property (@(posedge clk) disable iff (reset)
      (!ctl.interleaved && ctl.advance && !ctl.load && ctl.low == 2'h3)
      |=> (ctl.low == 2'h0))
      else $error("linear order did not wrap");
endmodule

`default_nettype wire

// [sbsc_sleep_ctrl.sv]
// Sleep sequencer: two-cycle entry into and exit from the retention state.
// Assumes the sleep request level is already clean on the core clock.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_map.svh"

module sbsc_sleep_ctrl (
   // Clock and reset
   input  wire logic clk,
   input  wire logic reset,
   // Sleep request and state
   sbsc_ctl_if.sleeper ctl
);
   import sbsc_pkg::*;

   sbsc_sleep_type state;  // Sequencer state
   logic [2:0]     cnt;    // Edges spent in a transition

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   // A request that drops mid entry simply returns to awake
   always_ff @(posedge clk) begin
      if (reset) begin
         state <= SBSC_AWAKE;
         cnt   <= `SBSC_SLEEP_CNT_RESET;
      end else begin
         case (state)
            SBSC_AWAKE: begin
               cnt <= 3'h1;
               if (ctl.sleep_req) state <= SBSC_ENTERING;
            end
            SBSC_ENTERING: begin
               cnt <= 3'(cnt + 3'h1);
               if (!ctl.sleep_req) state <= SBSC_AWAKE;
               else if (cnt >= 3'(`SBSC_SLEEP_ENTRY_CYCLES - 1)) state <= SBSC_ASLEEP;
            end
            SBSC_ASLEEP: begin
               cnt <= 3'h1;
               if (!ctl.sleep_req) state <= SBSC_LEAVING;
            end
            SBSC_LEAVING: begin
               cnt <= 3'(cnt + 3'h1);
               if (ctl.sleep_req) state <= SBSC_ASLEEP;
               else if (cnt >= 3'(`SBSC_SLEEP_EXIT_CYCLES - 1)) state <= SBSC_AWAKE;
            end
            default: state <= SBSC_AWAKE;
         endcase
      end
   end

   assign ctl.asleep = (state == SBSC_ASLEEP) || (state == SBSC_LEAVING);

   a_sleep_entry: assert property (@(posedge clk) disable iff (reset)
      $rose(ctl.sleep_req) ##1 ctl.sleep_req |=> ctl.asleep)
      else $error("sleep not entered in two cycles");
   a_sleep_exit: assert property (@(posedge clk) disable iff (reset)
      $fell(ctl.sleep_req) ##1 !ctl.sleep_req |=> !ctl.asleep)
      else $error("sleep not left in two cycles");
endmodule

`default_nettype wire

// [sbsc_bus_master.sv]
// Bus master model: drives every synchronous memory pin half a cycle before sampling.
// Assumes the memory samples on the rising edge of clk; mode and reset come from the bench.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_map.svh"

module sbsc_bus_master (
   // Clock
   input  wire logic                   clk,
   // Address and data
   output logic [`SBSC_ADDR_W-1:0]     addr,
   output logic [`SBSC_DATA_W-1:0]     data_in,
   // Selects and burst control
   output logic                        primary_select_n,
   output logic                        depth_select_hi,
   output logic                        depth_select_lo_n,
   output logic                        processor_addr_strobe_n,
   output logic                        controller_addr_strobe_n,
   output logic                        burst_advance_n,
   // Write, output enable and sleep
   output logic                        global_write_n,
   output logic                        byte_write_enable_n,
   output logic [`SBSC_LANES-1:0]      byte_lane_select_n,
   output logic                        output_enable_n,
   output logic                        sleep_request
);
   logic oe_want;  // Output enable level outside write starts

   // --------------------
   // Idle pins at time zero
   // --------------------
   initial begin
      {primary_select_n, depth_select_hi, depth_select_lo_n} = 3'h5;
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} = 3'h7;
      {global_write_n, byte_write_enable_n, byte_lane_select_n} = 6'h3f;
      addr = '0;
      data_in = '0;
      output_enable_n = 1'b1;
      sleep_request = 1'b0;
      oe_want = 1'b1;
   end

   // --------------------
   // Bus cycles
   // --------------------
   // One cycle, presented at the falling edge before the sampling edge
   task automatic drive(input logic [2:0] s, input logic ps, input logic cs, input logic stay,
                        input logic [5:0] w, input logic [`SBSC_ADDR_W-1:0] a,
                        input logic [`SBSC_DATA_W-1:0] d);
      logic wr;
      wr = !w[5] || (!w[4] && !(&w[3:0]));
      @(negedge clk);
      {primary_select_n, depth_select_hi, depth_select_lo_n} <= s;
      {processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n} <= {ps, cs, stay};
      {global_write_n, byte_write_enable_n, byte_lane_select_n} <= w;
      addr <= a;
      // Data lines flip in cycles that write nothing, so stale data never passes for a match
      data_in <= wr ? d : ~data_in;
      // Outputs released ahead of a write that opens a burst; free afterwards
      output_enable_n <= (wr && !(ps && cs)) ? 1'b1 : oe_want;
   endtask

   // Output enable is asynchronous, so it changes at once
   task automatic oe(input logic v);
      oe_want = v;
      output_enable_n <= v;
   endtask

   // Sleep level; a rise is preceded by a deselect, both edges come with idle selects
   task automatic sleep_level(input logic v);
      if (v)
         drive(3'h6, 1'b1, 1'b0, 1'b1, 6'h3f, '0, '0);
      drive(3'h5, 1'b1, 1'b1, 1'b1, 6'h3f, '0, '0);
      sleep_request <= v;
   endtask
endmodule

`default_nettype wire

// [tb_top.sv]
// Self-checking bench of the burst SRAM cycle control: writes, bursts, deselect, sleep.
// Assumes the bus master model drives every memory input except clock, mode and reset.
`timescale 1ns/1ps
`default_nettype none
`include "sbsc_map.svh"

module tb_top;
   // --------------------
   // Constants and nets
   // --------------------
   localparam logic [2:0]  ON   = 3'h2;      // All selects active
   localparam logic [2:0]  OFF  = 3'h5;      // All selects inactive
   localparam logic [5:0]  W_RD = 6'h3f;     // No write input low
   localparam logic [5:0]  W_ALL = 6'h1f;    // Global write low
   localparam logic [18:0] B    = 19'h2a5f0; // Base of the test region
   logic        clk, reset, burst_mode_interleaved, data_oe, sleep_state, burst_active;
   logic [35:0] data_out, data_in;
   logic [18:0] addr;
   logic        primary_select_n, depth_select_hi, depth_select_lo_n, processor_addr_strobe_n;
   logic        controller_addr_strobe_n, burst_advance_n, global_write_n, byte_write_enable_n;
   logic [3:0]  byte_lane_select_n;
   logic        output_enable_n, sleep_request;
   logic [35:0] shadow [0:15];               // Expected words of the test region
   int          fails = 0;
   int          check_count = 0;

   sbsc_top u_dut (.clk, .reset, .addr, .data_in, .data_out, .data_oe, .primary_select_n,
      .depth_select_hi, .depth_select_lo_n, .processor_addr_strobe_n, .controller_addr_strobe_n,
      .burst_advance_n, .burst_mode_interleaved, .global_write_n, .byte_write_enable_n,
      .byte_lane_select_n, .output_enable_n, .sleep_request, .sleep_state, .burst_active);
   sbsc_bus_master u_m (.clk, .addr, .data_in, .primary_select_n, .depth_select_hi,
      .depth_select_lo_n, .processor_addr_strobe_n, .controller_addr_strobe_n, .burst_advance_n,
      .global_write_n, .byte_write_enable_n, .byte_lane_select_n, .output_enable_n, .sleep_request);

   initial clk = 1'b0;
   always #2.5 clk = ~clk;

   // --------------------
   // Helpers
   // --------------------
   function automatic logic [35:0] pat(input logic [18:0] a);
      return {a[17:0], ~a[17:0]};
   endfunction

   task automatic chk36(input logic [35:0] got, input logic [35:0] exp);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk36({35'h0, got}, {35'h0, exp});
   endtask

   task automatic nop;
      u_m.drive(OFF, 1'b1, 1'b1, 1'b1, W_RD, 19'h0, 36'h0);
   endtask

   // Write cycle; a is where the write lands (external start or counter)
   task automatic wr(input logic cs, input logic stay, input logic [5:0] w,
                     input logic [18:0] a, input logic [35:0] d);
      u_m.drive(cs ? OFF : ON, 1'b1, cs, stay, w, cs ? 19'h0 : a, d);
      for (int l = 0; l < 4; l++)
         if (!w[5] || (!w[4] && !w[l]))
            shadow[a[3:0]][9*l +: 9] = d[9*l +: 9];
   endtask

   // Read burst: start, three advances, one suspend, deselect ds = {selects, strobes}
   task automatic burst(input logic [18:0] a, input logic [4:0] ds, input logic [5:0] w);
      logic [3:0] e [0:4];
      logic [1:0] k2;
      for (int k = 0; k < 5; k++) begin
         k2 = (k > 3) ? 2'h3 : 2'(k);
         e[k] = {a[3:2], burst_mode_interleaved ? a[1:0] ^ k2 : a[1:0] + k2};
         if (k == 0)
            u_m.drive(ON, 1'b0, 1'b1, 1'b1, w, a, ~pat(a));
         else
            u_m.drive(OFF, 1'b1, 1'b1, k == 4, W_RD, 19'h0, 36'h0);
         if (k > 1)
            chk36(data_out, shadow[e[k-2]]);
         if (k == 1)
            chk1(burst_active, 1'b1);
         if (k == 3) begin
            #0.5 u_m.oe(1'b1);
            #0.5 chk1(data_oe, 1'b0);
            u_m.oe(1'b0);
            #0.5 chk1(data_oe, 1'b1);
         end
      end
      u_m.drive(ds[4:2], ds[1], ds[0], 1'b1, W_RD, 19'h0, 36'h0);
      chk36(data_out, shadow[e[3]]);
      nop();
      chk36(data_out, shadow[e[4]]);
      chk1(data_oe, 1'b1);
      nop();
      chk1(data_oe, 1'b0);
      chk1(burst_active, 1'b0);
      $display("test burst from %h done", a);
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // --------------------
   // Tests
   // --------------------
   // Watchdog: the tests need under sixty cycles, so 4000 means a hang
   initial begin
      #20000;
      fails++;
      end_sim();
   end

   initial begin
      reset = 1'b1;
      burst_mode_interleaved = 1'b0;
      repeat (6) @(negedge clk);
      chk36(data_out, 36'h0);
      chk1(data_oe, 1'b0);
      chk1(burst_active, 1'b0);
      chk1(sleep_state, 1'b0);
      reset = 1'b0;
      u_m.oe(1'b0);
      $display("test reset done");
      // Back-to-back controller writes, then a write burst driven by the counter
      for (int i = 0; i < 9; i++)
         wr(1'b0, 1'b1, W_ALL, B + 19'(i), pat(B + 19'(i)));
      for (int i = 9; i < 12; i++) begin
         wr(1'b1, 1'b0, W_ALL, B + 19'(i), ~pat(B + 19'(i)));
         chk1(data_oe, 1'b0);
      end
      wr(1'b0, 1'b1, 6'h2a, B + 19'h1, 36'hf_ffff_ffff);
      wr(1'b0, 1'b1, 6'h2f, B + 19'h2, 36'h0);
      // Suspend write right after a read: the pending read must not reach the pins
      wr(1'b1, 1'b1, W_ALL, B + 19'h2, ~pat(B + 19'h2));
      nop();
      chk1(data_oe, 1'b0);
      $display("test writes done");
      burst(B + 19'h6, {3'h6, 2'h2}, W_ALL);
      burst_mode_interleaved = 1'b1;
      burst(B + 19'h9, {3'h0, 2'h1}, W_ALL);
      u_m.sleep_level(1'b1);
      nop();
      chk1(sleep_state, 1'b0);
      nop();
      chk1(sleep_state, 1'b1);
      u_m.drive(ON, 1'b1, 1'b0, 1'b1, W_ALL, B, 36'h0);
      nop();
      chk1(data_oe, 1'b0);
      u_m.sleep_level(1'b0);
      nop();
      chk1(sleep_state, 1'b1);
      nop();
      chk1(sleep_state, 1'b0);
      $display("test sleep done");
      burst(B + 19'h1, {3'h6, 2'h2}, W_RD);
      end_sim();
   end
endmodule

`default_nettype wire
